// *** rtl/acmc_pkg.sv ***
// Constants, field layouts and types shared by the audio clock mode controller
package acmc_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] ACMC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] ACMC_STATUS_OFS = 8'h04;
    localparam logic [7:0] ACMC_FRAMES_OFS = 8'h08;

    // Control register field positions
    localparam int ACMC_CTRL_PLL_POWER_POS = 0;
    localparam int ACMC_CTRL_MASTER_POS    = 1;
    localparam int ACMC_CTRL_MCLK_OE_POS   = 2;
    localparam int ACMC_CTRL_ADC_L_POS     = 3;
    localparam int ACMC_CTRL_ADC_R_POS     = 4;
    localparam int ACMC_CTRL_BCLK_RAT_POS  = 5;
    localparam int ACMC_CTRL_MDIV_POS      = 6;
    localparam int ACMC_CTRL_REFSEL_POS    = 8;
    localparam int ACMC_CTRL_RATE_POS      = 12;
    localparam int ACMC_CTRL_WIDTH         = 16;

    // Reset value of the control register: slave, PLL off, outputs quiet
    localparam logic [15:0] ACMC_CTRL_RESET = 16'h0000;

    // Frame clock rising edges from ADC power-up to valid output data
    localparam logic [10:0] ACMC_ADC_VALID_FRAMES = 11'h423;

    // PLL lock time and the clock rate it is counted in
    localparam int ACMC_PLL_LOCK_TIME_MS = 40;
    localparam int ACMC_CLK_FREQ_KHZ     = 200000;
    localparam int ACMC_PLL_LOCK_CYCLES  = ACMC_PLL_LOCK_TIME_MS * ACMC_CLK_FREQ_KHZ;

    // Bits per half frame for each bit clock ratio setting (32fs and 64fs)
    localparam logic [5:0] ACMC_HALF_FRAME_32 = 6'h10;
    localparam logic [5:0] ACMC_HALF_FRAME_64 = 6'h20;

    // Clock modes derived from the power and master-select bits and bit 2 of the PLL reference select
    typedef enum logic [2:0] {
        ACMC_MODE_EXT_SLAVE,
        ACMC_MODE_PLL_SLAVE_MCLK,
        ACMC_MODE_PLL_SLAVE_FRAME,
        ACMC_MODE_PLL_MASTER,
        ACMC_MODE_UNDEFINED
    } acmc_mode_t;

    // Control register contents, bit 0 first from the right
    typedef struct packed {
        logic [3:0] rate_select;
        logic [3:0] pll_ref_select;
        logic [1:0] mclk_out_divider;
        logic       bitclk_ratio;
        logic       adc_right_power;
        logic       adc_left_power;
        logic       mclk_out_enable;
        logic       master_select;
        logic       pll_power_on;
    } acmc_ctrl_t;

    // Status register contents
    typedef struct packed {
        logic       mclk_invalid;
        logic       ref_from_mclk;
        logic       clocks_driven;
        logic       adc_data_valid;
        logic       pll_locked;
        acmc_mode_t mode;
    } acmc_status_t;

endpackage : acmc_pkg

// *** rtl/acmc_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
module acmc_pin_sync
    import acmc_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Shift the pin through three flops
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Take the new level only when the two late stages agree
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            level_out <= RESET_LEVEL;
        else if (stage2 == stage3)
            level_out <= stage3;
    end

endmodule : acmc_pin_sync

// *** rtl/acmc_clock_mode.sv ***
// Audio clock mode controller: mode decode, clock pin control and ADC data gating
// Function
// - Mode from PLL power and master-select bits
// - Slave mode 1 references master clock pin
// - Slave mode 2 locks to frame/bit clock
// - Undefined combo gives invalid master clock out
// - Master clock out low unless enabled
// - ADC data valid after 1059 frame edges
// - Power-down pin low resets all control
// - Master-select 1 with PLL on is master; reset starts slave
// - Master clocks held low until PLL lock
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
module acmc_clock_mode
    import acmc_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = ACMC_PLL_LOCK_CYCLES,
    parameter int BCLK_HALF_CYCLES = 4
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        powerdown_pin_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        mclk_in_pin_in,
    input  wire logic        frame_clock_in,
    output logic             frame_clock_out,
    output logic             frame_clock_oe_n_out,
    input  wire logic        bit_clock_in,
    output logic             bit_clock_out,
    output logic             bit_clock_oe_n_out,
    output logic             mclk_out,
    input  wire logic        adc_serial_bit_in,
    output logic             serial_data_out,
    output logic             serial_data_valid_out,
    output acmc_mode_t       mode_out,
    output logic             pll_ref_from_mclk_out
);

    // Elaboration checks on the parameters
    if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES > 16777215)
        $error("PLL_LOCK_CYCLES out of range");
    if (BCLK_HALF_CYCLES < 1 || BCLK_HALF_CYCLES > 255)
        $error("BCLK_HALF_CYCLES out of range");

    localparam logic [23:0] LOCK_LAST = 24'(PLL_LOCK_CYCLES - 1);
    localparam logic [7:0]  BCLK_LAST = 8'(BCLK_HALF_CYCLES - 1);

    // Decode the mode from the control bits
    function automatic acmc_mode_t decode_mode(input acmc_ctrl_t c);
        if (c.pll_power_on && c.master_select)
            decode_mode = ACMC_MODE_PLL_MASTER;
        else if (c.pll_power_on && c.pll_ref_select[2])
            decode_mode = ACMC_MODE_PLL_SLAVE_MCLK;
        else if (c.pll_power_on)
            decode_mode = ACMC_MODE_PLL_SLAVE_FRAME;
        else if (c.master_select)
            decode_mode = ACMC_MODE_UNDEFINED;
        else
            decode_mode = ACMC_MODE_EXT_SLAVE;
    endfunction : decode_mode

    // Merge written bytes into a register word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  sel);
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                result[i*8 +: 8] = new_word[i*8 +: 8];
        merge_bytes = result;
    endfunction : merge_bytes

    logic         powerdown_level;
    logic         ctl_rst;
    logic [15:0]  ctrl_word;
    acmc_ctrl_t   ctrl;
    acmc_mode_t   mode;
    acmc_status_t status;
    logic         bus_req;
    logic [23:0]  lock_count;
    logic         pll_locked;
    logic         prev_pll_power;
    logic [3:0]   prev_rate;
    logic [7:0]   bclk_div;
    logic         bclk_gen;
    logic [5:0]   bit_count;
    logic         fclk_gen;
    logic [7:0]   mclk_div;
    logic         frame_level;
    logic         bit_level;
    logic         frame_prev;
    logic         frame_rise;
    logic         adc_any_power;
    logic         adc_prev_power;
    logic [10:0]  frame_count;
    logic         adc_valid;
    logic         drive_clocks;
    logic [5:0]   half_frame;

    // Power-down pin is synchronised and acts as a reset of all control logic
    acmc_pin_sync #(.RESET_LEVEL(1'b1)) u_pdn_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (powerdown_pin_n_in),
        .level_out (powerdown_level)
    );
    assign ctl_rst = rst_in | ~powerdown_level;

    // Frame and bit clock inputs from the host
    acmc_pin_sync u_frame_sync (
        .clk_in    (clk_in),
        .rst_in    (ctl_rst),
        .pin_in    (frame_clock_in),
        .level_out (frame_level)
    );
    acmc_pin_sync u_bit_sync (
        .clk_in    (clk_in),
        .rst_in    (ctl_rst),
        .pin_in    (bit_clock_in),
        .level_out (bit_level)
    );

    // Mode follows the control word combinationally so a write takes effect at once
    assign ctrl = acmc_ctrl_t'(ctrl_word);
    assign mode = decode_mode(ctrl);
    assign mode_out = mode;
    assign pll_ref_from_mclk_out = (mode == ACMC_MODE_PLL_SLAVE_MCLK);

    // Wishbone request and one-cycle acknowledge
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;

    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            wb_ack_out <= 1'b0;
        else
            wb_ack_out <= bus_req;
    end

    // Control register write; reset leaves the device in slave mode
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            ctrl_word <= ACMC_CTRL_RESET;
        else if (bus_req && wb_we_in && wb_adr_in == ACMC_CTRL_OFS)
            ctrl_word <= 16'(merge_bytes({16'h0000, ctrl_word}, wb_dat_in, wb_sel_in));
    end

    // Status word
    always_comb
    begin
        status.mode           = mode;
        status.pll_locked     = pll_locked;
        status.adc_data_valid = adc_valid;
        status.clocks_driven  = drive_clocks;
        status.ref_from_mclk  = pll_ref_from_mclk_out;
        status.mclk_invalid   = (mode == ACMC_MODE_UNDEFINED) && ctrl.mclk_out_enable;
    end

    // Registered read data; unmapped offsets read as zero
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            wb_dat_out <= 32'h0000_0000;
        else if (bus_req && !wb_we_in)
        begin
            if (wb_adr_in == ACMC_CTRL_OFS)
                wb_dat_out <= {16'h0000, ctrl_word};
            else if (wb_adr_in == ACMC_STATUS_OFS)
                wb_dat_out <= {24'h000000, status};
            else if (wb_adr_in == ACMC_FRAMES_OFS)
                wb_dat_out <= {21'h000000, frame_count};
            else
                wb_dat_out <= 32'h0000_0000;
        end
    end

    // PLL lock model: restarts on power-up or a rate change
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
        begin
            prev_pll_power <= 1'b0;
            prev_rate      <= 4'h0;
            lock_count     <= 24'h000000;
            pll_locked     <= 1'b0;
        end
        else
        begin
            prev_pll_power <= ctrl.pll_power_on;
            prev_rate      <= ctrl.rate_select;
            if (!ctrl.pll_power_on || (ctrl.pll_power_on && !prev_pll_power)
                || ctrl.rate_select != prev_rate)
            begin
                lock_count <= 24'h000000;
                pll_locked <= 1'b0;
            end
            else if (lock_count == LOCK_LAST)
                pll_locked <= 1'b1;
            else
                lock_count <= lock_count + 24'h000001;
        end
    end

    // Master clocks run only in PLL master mode once locked
    assign drive_clocks = (mode == ACMC_MODE_PLL_MASTER) && pll_locked;
    assign half_frame   = ctrl.bitclk_ratio ? ACMC_HALF_FRAME_64 : ACMC_HALF_FRAME_32;

    // Bit clock divider
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst || !drive_clocks)
        begin
            bclk_div <= 8'h00;
            bclk_gen <= 1'b0;
        end
        else if (bclk_div == BCLK_LAST)
        begin
            bclk_div <= 8'h00;
            bclk_gen <= ~bclk_gen;
        end
        else
            bclk_div <= bclk_div + 8'h01;
    end

    // Frame clock changes only on a falling bit clock, never with a rising one
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst || !drive_clocks)
        begin
            bit_count <= 6'h00;
            fclk_gen  <= 1'b0;
        end
        else if (bclk_div == BCLK_LAST && bclk_gen)
        begin
            if (bit_count == half_frame - 6'h01)
            begin
                bit_count <= 6'h00;
                fclk_gen  <= ~fclk_gen;
            end
            else
                bit_count <= bit_count + 6'h01;
        end
    end

    // Pin directions: outputs in master mode, inputs in all slave modes
    assign frame_clock_out      = fclk_gen;
    assign bit_clock_out        = bclk_gen;
    assign frame_clock_oe_n_out = (mode != ACMC_MODE_PLL_MASTER);
    assign bit_clock_oe_n_out   = (mode != ACMC_MODE_PLL_MASTER);

    // Master clock output divider
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            mclk_div <= 8'h00;
        else
            mclk_div <= mclk_div + 8'h01;
    end

    // Master clock out: low when disabled, divider bit 0 XOR the master clock pin in the undefined mode
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst || !ctrl.mclk_out_enable)
            mclk_out <= 1'b0;
        else if (mode == ACMC_MODE_UNDEFINED)
            mclk_out <= mclk_div[0] ^ mclk_in_pin_in;
        else
            mclk_out <= mclk_div[ctrl.mclk_out_divider];
    end

    // Frame rising edge from the generated or the received frame clock
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            frame_prev <= 1'b0;
        else
            frame_prev <= (mode == ACMC_MODE_PLL_MASTER) ? fclk_gen : frame_level;
    end
    assign frame_rise = ((mode == ACMC_MODE_PLL_MASTER) ? fclk_gen : frame_level) & ~frame_prev;

    // ADC power edge tracking
    assign adc_any_power = ctrl.adc_left_power | ctrl.adc_right_power;

    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            adc_prev_power <= 1'b0;
        else
            adc_prev_power <= adc_any_power;
    end

    // Count frame edges after an ADC power-up before output data is trusted
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst || !adc_any_power || (adc_any_power && !adc_prev_power))
        begin
            frame_count <= 11'h000;
            adc_valid   <= 1'b0;
        end
        else if (frame_rise && !adc_valid)
        begin
            frame_count <= frame_count + 11'h001;
            if (frame_count + 11'h001 == ACMC_ADC_VALID_FRAMES)
                adc_valid <= 1'b1;
        end
    end

    // Serial output is held low until the ADC data is valid
    always_ff @(posedge clk_in)
    begin
        if (ctl_rst)
            serial_data_out <= 1'b0;
        else
            serial_data_out <= adc_valid & adc_serial_bit_in;
    end
    assign serial_data_valid_out = adc_valid;

endmodule : acmc_clock_mode

// *** testbench/acmc_chk.sv ***
// Port checker of the clock mode controller
module acmc_chk
    import acmc_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES  = 20,
    parameter int BCLK_HALF_CYCLES = 4
)
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        powerdown_pin_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic        wb_ack_out,
    input wire logic        frame_clock_in,
    input wire logic        frame_clock_out,
    input wire logic        frame_clock_oe_n_out,
    input wire logic        bit_clock_out,
    input wire logic        bit_clock_oe_n_out,
    input wire logic        mclk_out,
    input wire logic        serial_data_out,
    input wire logic        serial_data_valid_out,
    input wire acmc_mode_t  mode_out,
    input wire logic        pll_ref_from_mclk_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in || !powerdown_pin_n_in);
    acmc_ctrl_t  sh;
    int          w;
    logic        seen;
    logic [10:0] fc;
    logic        fp;
    logic        fs;
    logic        mst;
    assign mst = mode_out == ACMC_MODE_PLL_MASTER;
    assign fs  = mst ? frame_clock_out : frame_clock_in;
    // Expected mode from a control word
    function automatic acmc_mode_t exp_mode(input acmc_ctrl_t c);
        if (c.master_select)
            return c.pll_power_on ? ACMC_MODE_PLL_MASTER : ACMC_MODE_UNDEFINED;
        if (!c.pll_power_on)
            return ACMC_MODE_EXT_SLAVE;
        return c.pll_ref_select[2] ? ACMC_MODE_PLL_SLAVE_MCLK : ACMC_MODE_PLL_SLAVE_FRAME;
    endfunction : exp_mode
    // Shadow control word, taken at the acknowledged edge; the bench writes all lanes
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !powerdown_pin_n_in)
            sh <= '0;
        else if (wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_adr_in == ACMC_CTRL_OFS)
            sh <= wb_dat_in[15:0];
    end
    // Cycles in master mode until the bit clock first rises
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !(sh.pll_power_on && sh.master_select))
        begin
            w <= 0;
            seen <= 1'b0;
        end
        else if (bit_clock_out)
            seen <= 1'b1;
        else if (!seen)
            w <= w + 1;
    end
    // Frame rising edges since an ADC power bit rose
    always_ff @(posedge clk_in)
    begin
        fp <= fs;
        if (rst_in || !(sh.adc_left_power || sh.adc_right_power))
            fc <= '0;
        else if ($rose(sh.adc_left_power) || $rose(sh.adc_right_power))
            fc <= '0;
        else if (fs && !fp && fc != 11'h7ff)
            fc <= fc + 11'h001;
    end
    mode_decode_a: assert property (!wb_cyc_in |-> mode_out == exp_mode(sh))
        else $error("mode differs from control word");
    ref_sel_a: assert property (!wb_cyc_in |-> pll_ref_from_mclk_out
        == (exp_mode(sh) == ACMC_MODE_PLL_SLAVE_MCLK)) else $error("reference flag wrong");
    slave_pins_a: assert property (!mst |-> frame_clock_oe_n_out && bit_clock_oe_n_out)
        else $error("slave mode drives clocks");
    master_pins_a: assert property (mst |-> !frame_clock_oe_n_out && !bit_clock_oe_n_out)
        else $error("master mode leaves clocks undriven");
    mclk_quiet_a: assert property ((!sh.mclk_out_enable)[*2] |-> !mclk_out)
        else $error("master clock out not low");
    mclk_fast_a: assert property ((sh.mclk_out_enable && sh.mclk_out_divider == 2'h0
        && !mode_out[2] && !wb_cyc_in)[*3] |-> mclk_out != $past(mclk_out))
        else $error("mclk not toggling");
    lock_hold_a: assert property (w != 0 && w < PLL_LOCK_CYCLES - 2 |-> !bit_clock_out && !fs)
        else $error("clocks run before lock");
    clk_start_a: assert property (!seen |-> w <= PLL_LOCK_CYCLES + 2 * BCLK_HALF_CYCLES + 4)
        else $error("bit clock late after lock");
    adc_early_a: assert property (serial_data_valid_out |-> fc >= 11'h422)
        else $error("data valid too early");
    adc_late_a: assert property (fc >= 11'h425 |-> serial_data_valid_out)
        else $error("data valid too late");
    data_gate_a: assert property ((!serial_data_valid_out)[*2] |-> !serial_data_out)
        else $error("data out while invalid");
    ack_timing_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("ack timing wrong");
    pd_reset_a: assert property (disable iff (rst_in) (!powerdown_pin_n_in)[*6] |->
        mode_out == ACMC_MODE_EXT_SLAVE && frame_clock_oe_n_out && !mclk_out) else $error("no reset");
endmodule : acmc_chk

// *** testbench/acmc_host_model.sv ***
// Host audio processor model driving the serial audio clocks
module acmc_host_model
#(
    parameter int HALF_BITS = 16
)
(
    input  wire logic clk_in,
    input  wire logic run_in,
    input  wire logic mclk_gnd_in,
    output logic      frame_clock_out,
    output logic      bit_clock_out,
    output logic      mclk_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int n = 0;
    initial mclk_out = 1'b0;
    initial frame_clock_out = 1'b0;
    initial bit_clock_out = 1'b0;
    // Master clock pin, grounded on request
    always @(posedge clk_in)
        mclk_out <= mclk_gnd_in ? 1'b0 : !mclk_out;
    // Bit clock of 2*HALF_BITS per frame; frame flips on falling bit edges only
    always @(posedge clk_in)
    begin
        if (!run_in)
        begin
            bit_clock_out <= 1'b0; // Pulled low when released
            frame_clock_out <= 1'b0;
            n <= 0;
        end
        else
        begin
            bit_clock_out <= !bit_clock_out;
            if (bit_clock_out)
            begin
                n <= (n == HALF_BITS - 1) ? 0 : n + 1;
                if (n == HALF_BITS - 1)
                    frame_clock_out <= !frame_clock_out;
            end
        end
    end
endmodule : acmc_host_model

// *** testbench/tb_top.sv ***
// Self-checking bench of the clock mode controller
module tb_top
    import acmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BH = 4;
    logic clk_in = 1'b0, rst_in = 1'b1, powerdown_pin_n_in = 1'b1, adc_serial_bit_in = 1'b0;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out, mclk_in_pin_in;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, seed = 32'h10;
    logic frame_clock_in, frame_clock_out, frame_clock_oe_n_out, host_frame, host_run = 1'b0;
    logic bit_clock_in, bit_clock_out, bit_clock_oe_n_out, host_bit, mclk_gnd_in = 1'b0;
    logic mclk_out, serial_data_out, serial_data_valid_out, pll_ref_from_mclk_out;
    acmc_mode_t mode_out;
    int err_count = 0, comparisons = 0, cycles = 0;
    always #2.5 clk_in = !clk_in;
    // Wire levels from the controller's output enables
    assign frame_clock_in = frame_clock_oe_n_out ? host_frame : frame_clock_out;
    assign bit_clock_in = bit_clock_oe_n_out ? host_bit : bit_clock_out;
    acmc_clock_mode #(.PLL_LOCK_CYCLES(20), .BCLK_HALF_CYCLES(BH)) uut (.clk_in, .rst_in,
        .powerdown_pin_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .mclk_in_pin_in, .frame_clock_in, .frame_clock_out,
        .frame_clock_oe_n_out, .bit_clock_in, .bit_clock_out, .bit_clock_oe_n_out, .mclk_out,
        .adc_serial_bit_in, .serial_data_out, .serial_data_valid_out, .mode_out,
        .pll_ref_from_mclk_out);
    acmc_host_model #(.HALF_BITS(16)) host (.clk_in, .run_in(host_run && frame_clock_oe_n_out),
        .mclk_gnd_in, .frame_clock_out(host_frame), .bit_clock_out(host_bit),
        .mclk_out(mclk_in_pin_in));
    // Next pseudo-random word
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs
    // Mode expected for pll, master and reference bits
    function automatic acmc_mode_t exp_mode(input logic [2:0] i);
        if (i[1])
            return i[0] ? ACMC_MODE_PLL_MASTER : ACMC_MODE_UNDEFINED;
        if (!i[0])
            return ACMC_MODE_EXT_SLAVE;
        return i[2] ? ACMC_MODE_PLL_SLAVE_MCLK : ACMC_MODE_PLL_SLAVE_FRAME;
    endfunction : exp_mode
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int t;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        for (t = 0; t < 50 && wb_ack_out !== 1'b1; t++)
            @(posedge clk_in);
        q = wb_dat_out;
        chk("ack", 32'h1, {31'h0, wb_ack_out});
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(n, e, q & m);
    endtask : rd
    // Length of one level of the frame clock or master clock output
    task automatic half(input logic f, output int t);
        logic m;
        @(negedge clk_in);
        m = f ? frame_clock_out : mclk_out;
        for (t = 0; t < 999 && (f ? frame_clock_out : mclk_out) === m; t++)
            @(negedge clk_in);
        for (t = 0; t < 999 && (f ? frame_clock_out : mclk_out) !== m; t++)
            @(negedge clk_in);
    endtask : half
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // Hang limit
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_count++;
            end_sim();
        end
    end
    // Main sequence
    initial
    begin
        logic [15:0] c;
        int t;
        int n;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        host_run <= 1'b1;
        rd("ctrl reset", ACMC_CTRL_OFS, 32'hffffffff, {16'h0, ACMC_CTRL_RESET});
        wr(8'h0c, 32'hffff);
        rd("unmapped", 8'h0c, 32'hffffffff, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            c = {seed[15:11], i[2], seed[9:5], 2'h0, seed[2], i[1:0]};
            mclk_gnd_in <= !i[2];
            wr(ACMC_CTRL_OFS, {16'h0, c});
            rd("ctrl", ACMC_CTRL_OFS, 32'hffffffff, {16'h0, c});
            rd("mode", ACMC_STATUS_OFS, 32'h7, {29'h0, exp_mode(i[2:0])});
            chk("drive", {31'h0, !i[0] || !i[1]}, {31'h0, bit_clock_oe_n_out});
        end
        $display("mode test done");
        wr(ACMC_CTRL_OFS, 32'h0);
        wr(ACMC_CTRL_OFS, {26'h0, seed[0], 5'h03});
        chk("held low", 32'h0, {30'h0, bit_clock_out, frame_clock_out});
        repeat (40) @(posedge clk_in);
        rd("locked", ACMC_STATUS_OFS, 32'h8, 32'h8);
        half(1'b1, t);
        chk("frame half", (seed[0] ? 32'h20 : 32'h10) * 2 * BH, t);
        for (int d = 0; d < 4; d++)
        begin
            wr(ACMC_CTRL_OFS, {24'h0, d[1:0], 6'h07});
            half(1'b0, t);
            chk("mclk half", 32'h1 << d, t);
        end
        wr(ACMC_CTRL_OFS, 32'h3);
        n = 0;
        repeat (20) @(negedge clk_in) n += mclk_out;
        chk("mclk off", 32'h0, n);
        $display("master test done");
        wr(ACMC_CTRL_OFS, 32'h0);
        adc_serial_bit_in <= 1'b1;
        @(negedge frame_clock_in);
        wr(ACMC_CTRL_OFS, 32'h8);
        n = 0;
        c = 16'h0;
        for (t = 0; t < 80000 && serial_data_valid_out !== 1'b1; t++)
        begin
            @(negedge clk_in);
            n += frame_clock_in && !c[0];
            c[0] = frame_clock_in;
            c[1] = c[1] | serial_data_out;
        end
        chk("frames", 32'h423, n);
        chk("early data", 32'h0, {31'h0, c[1]});
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            @(posedge clk_in);
            adc_serial_bit_in <= seed[3];
            @(posedge clk_in);
            @(negedge clk_in);
            chk("data", {31'h0, seed[3]}, {31'h0, serial_data_out});
        end
        $display("adc test done");
        wr(ACMC_CTRL_OFS, 32'h7);
        powerdown_pin_n_in <= 1'b0;
        repeat (7) @(posedge clk_in);
        chk("pd mode", {29'h0, ACMC_MODE_EXT_SLAVE}, {29'h0, mode_out});
        powerdown_pin_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd("pd ctrl", ACMC_CTRL_OFS, 32'hffffffff, 32'h0);
        $display("powerdown test done");
        end_sim();
    end
endmodule : tb_top

bind acmc_clock_mode acmc_chk #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES),
    .BCLK_HALF_CYCLES(BCLK_HALF_CYCLES)) chk (.clk_in, .rst_in, .powerdown_pin_n_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out, .frame_clock_in,
    .frame_clock_out, .frame_clock_oe_n_out, .bit_clock_out, .bit_clock_oe_n_out, .mclk_out,
    .serial_data_out, .serial_data_valid_out, .mode_out, .pll_ref_from_mclk_out);
